// ### hw/dtc_pkg.sv
// Constants, register map and carrier types for the digital I/O and trigger counter block
package dtc_pkg;
   localparam int WIDE_W = 8;
   localparam int NARROW_W = 4;
   localparam int LINES = WIDE_W + NARROW_W;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W = 32;

   localparam logic [ADDR_W-1:0] OFS_DIR = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_OUT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_DRIVE = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IN = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_FUNC = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;

   // Function register bit positions
   localparam int FB_MODE = 0;
   localparam int FB_FALL = 1;
   localparam int FB_ARM = 2;
   localparam int FB_FIRED = 3;
   // Status register bit positions
   localparam int SB_SUSPEND = 0;
   localparam int SB_AUX = 1;

   localparam logic [LINES-1:0] LINES_RST = 12'h000;
   localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

   typedef enum logic [0:0] {
      FN_TRIGGER = 1'b0,
      FN_COUNTER = 1'b1
   } dtc_func_e;

   typedef struct packed {
      logic armed;
      logic fired;
      logic fall_edge;
      dtc_func_e mode;
   } dtc_func_s;

   localparam dtc_func_s FUNC_RST = '{armed: 1'b0, fired: 1'b0, fall_edge: 1'b0,
                                      mode: FN_TRIGGER};
endpackage

// ### hw/dtc_sync_edge.sv
// Two-flop synchroniser with a registered edge detector behind it
`timescale 1ns/1ps
`default_nettype none
module dtc_sync_edge #(
   parameter int WIDTH = 1
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] level_o,
   output logic [WIDTH-1:0] rise_o,
   output logic [WIDTH-1:0] fall_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] last_q;
   // Edges stay masked until last_q holds a real sample, so a pin idling high
   // never shows a false rising edge after reset; an edge in that gap is lost
   logic [2:0] warm_q;

   // Only sync_q reads meta_q; edges are taken after the second flop
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         meta_q <= '0;
         sync_q <= '0;
         last_q <= '0;
         warm_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
         last_q <= sync_q;
         warm_q <= {warm_q[1:0], 1'b1};
      end
   end

   assign level_o = sync_q;
   assign rise_o = warm_q[2] ? (sync_q & ~last_q) : '0;
   assign fall_o = warm_q[2] ? (~sync_q & last_q) : '0;
endmodule
`default_nettype wire

// ### hw/dtc_dio.sv
// Digital I/O ports, function input trigger/counter and auxiliary supply gate
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dtc_dio (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic [dtc_pkg::ADDR_W-1:0] addr_i,
   input wire logic [dtc_pkg::DATA_W-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [dtc_pkg::DATA_W-1:0] rd_data_o,
   input wire logic [dtc_pkg::WIDE_W-1:0] wide_port_lines_i,
   output logic [dtc_pkg::WIDE_W-1:0] wide_port_lines_o,
   output logic [dtc_pkg::WIDE_W-1:0] wide_port_lines_oe_o,
   input wire logic [dtc_pkg::NARROW_W-1:0] narrow_port_lines_i,
   output logic [dtc_pkg::NARROW_W-1:0] narrow_port_lines_o,
   output logic [dtc_pkg::NARROW_W-1:0] narrow_port_lines_oe_o,
   input wire logic function_input_i,
   output logic acquisition_start_trigger_o,
   input wire logic bus_suspend_i,
   output logic aux_supply_en_o
);
   localparam int L = dtc_pkg::LINES;
   localparam int W = dtc_pkg::WIDE_W;

   // Software-visible state
   logic [L-1:0] dir_q, dir_d;
   logic [L-1:0] out_q, out_d;
   logic [L-1:0] drv_q, drv_d;
   dtc_pkg::dtc_func_s func_q, func_d;
   logic [dtc_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [dtc_pkg::DATA_W-1:0] rd_data_q, rd_data_d;
   // Pin-facing state
   logic [L-1:0] pin_o_q, pin_o_d;
   logic [L-1:0] pin_oe_q, pin_oe_d;
   logic trig_q, trig_d;
   logic aux_q, aux_d;

   logic [L-1:0] pins_sync;
   logic fn_level, fn_rise, fn_fall, sel_edge;
   logic wr_dir, wr_out, wr_drv, wr_func, wr_cnt;

   function automatic logic hit(input logic [dtc_pkg::ADDR_W-1:0] a,
                                input logic [dtc_pkg::ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   // Line fields sit in the low bits of a data word, wide port first
   function automatic logic [dtc_pkg::LINES-1:0] line_field(
         input logic [dtc_pkg::DATA_W-1:0] d);
      line_field = d[dtc_pkg::LINES-1:0];
   endfunction

   dtc_sync_edge #(.WIDTH(L)) u_pin_sync (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .async_i({narrow_port_lines_i, wide_port_lines_i}),
      .level_o(pins_sync),
      .rise_o(),
      .fall_o()
   );

   // Function input edges are masked while the synchroniser fills after reset,
   // so an input idling high cannot fire an armed trigger by itself
   dtc_sync_edge #(.WIDTH(1)) u_fn_sync (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .async_i(function_input_i),
      .level_o(fn_level),
      .rise_o(fn_rise),
      .fall_o(fn_fall)
   );

   assign wr_dir = wr_i && hit(addr_i, dtc_pkg::OFS_DIR);
   assign wr_out = wr_i && hit(addr_i, dtc_pkg::OFS_OUT);
   assign wr_drv = wr_i && hit(addr_i, dtc_pkg::OFS_DRIVE);
   assign wr_func = wr_i && hit(addr_i, dtc_pkg::OFS_FUNC);
   assign wr_cnt = wr_i && hit(addr_i, dtc_pkg::OFS_COUNT);
   assign sel_edge = func_q.fall_edge ? fn_fall : fn_rise;

   // Register writes; lines only change when software writes
   always_comb begin
      dir_d = wr_dir ? line_field(wr_data_i) : dir_q;
      out_d = wr_out ? line_field(wr_data_i) : out_q;
      drv_d = wr_drv ? line_field(wr_data_i) : drv_q;
   end

   // Pin drive: open-drain unless push-pull chosen for the line
   always_comb begin
      for (int i = 0; i < L; i++) begin
         pin_o_d[i] = drv_q[i] ? out_q[i] : 1'b0;
         pin_oe_d[i] = dir_q[i] && (drv_q[i] || !out_q[i]);
      end
   end

   // Function input: trigger arming and event counter
   always_comb begin
      func_d = func_q;
      trig_d = 1'b0;
      cnt_d = cnt_q;
      if (func_q.mode == dtc_pkg::FN_TRIGGER && func_q.armed && sel_edge) begin
         trig_d = 1'b1;
         func_d.armed = 1'b0;
         func_d.fired = 1'b1;
      end
      if (wr_func) begin
         func_d.mode = dtc_pkg::dtc_func_e'(wr_data_i[dtc_pkg::FB_MODE]);
         func_d.fall_edge = wr_data_i[dtc_pkg::FB_FALL];
         // An edge that fires in this same cycle keeps its fired flag
         if (wr_data_i[dtc_pkg::FB_ARM] && !trig_d) begin
            func_d.armed = (wr_data_i[dtc_pkg::FB_MODE] == 1'b0);
            func_d.fired = 1'b0;
         end
         if (wr_data_i[dtc_pkg::FB_MODE]) begin
            func_d.armed = 1'b0;
         end
      end
      if (func_q.mode == dtc_pkg::FN_COUNTER && fn_fall) begin
         cnt_d = cnt_q + dtc_pkg::CNT_ONE;
      end
      if (wr_cnt) begin
         // A loaded value still sees an edge of the same cycle
         cnt_d = wr_data_i + ((func_q.mode == dtc_pkg::FN_COUNTER && fn_fall)
                              ? dtc_pkg::CNT_ONE : dtc_pkg::CNT_RST);
      end
   end

   // Auxiliary supply is enabled while not in suspend, with one flop of delay
   always_comb begin
      aux_d = !bus_suspend_i;
   end

   // Read data: the input port is sampled only when software reads it
   always_comb begin
      rd_data_d = dtc_pkg::DATA_ZERO;
      if (rd_i) begin
         case (addr_i)
            dtc_pkg::OFS_DIR: rd_data_d[L-1:0] = dir_q;
            dtc_pkg::OFS_OUT: rd_data_d[L-1:0] = out_q;
            dtc_pkg::OFS_DRIVE: rd_data_d[L-1:0] = drv_q;
            dtc_pkg::OFS_IN: rd_data_d[L-1:0] = pins_sync;
            dtc_pkg::OFS_FUNC: begin
               rd_data_d[dtc_pkg::FB_MODE] = func_q.mode;
               rd_data_d[dtc_pkg::FB_FALL] = func_q.fall_edge;
               rd_data_d[dtc_pkg::FB_ARM] = func_q.armed;
               rd_data_d[dtc_pkg::FB_FIRED] = func_q.fired;
            end
            dtc_pkg::OFS_COUNT: rd_data_d = cnt_q;
            dtc_pkg::OFS_STATUS: begin
               rd_data_d[dtc_pkg::SB_SUSPEND] = bus_suspend_i;
               rd_data_d[dtc_pkg::SB_AUX] = aux_q;
            end
            default: rd_data_d = dtc_pkg::DATA_ZERO;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         dir_q <= dtc_pkg::LINES_RST;
         out_q <= dtc_pkg::LINES_RST;
         drv_q <= dtc_pkg::LINES_RST;
         pin_o_q <= dtc_pkg::LINES_RST;
         pin_oe_q <= dtc_pkg::LINES_RST;
         func_q <= dtc_pkg::FUNC_RST;
         cnt_q <= dtc_pkg::CNT_RST;
         trig_q <= 1'b0;
         aux_q <= 1'b0;
         rd_data_q <= dtc_pkg::DATA_ZERO;
      end else begin
         dir_q <= dir_d;
         out_q <= out_d;
         drv_q <= drv_d;
         pin_o_q <= pin_o_d;
         pin_oe_q <= pin_oe_d;
         func_q <= func_d;
         cnt_q <= cnt_d;
         trig_q <= trig_d;
         aux_q <= aux_d;
         rd_data_q <= rd_data_d;
      end
   end

   assign wide_port_lines_o = pin_o_q[W-1:0];
   assign wide_port_lines_oe_o = pin_oe_q[W-1:0];
   assign narrow_port_lines_o = pin_o_q[L-1:W];
   assign narrow_port_lines_oe_o = pin_oe_q[L-1:W];
   assign acquisition_start_trigger_o = trig_q;
   assign aux_supply_en_o = aux_q;
   assign rd_data_o = rd_data_q;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);

   property reset_off_p;
      @(posedge clock_i) disable iff (1'b0)
      reset_i |=> (pin_oe_q == dtc_pkg::LINES_RST) && !trig_q;
   endproperty
   reset_lines_a: assert property (reset_off_p)
      else $error("lines driven after reset");

   input_undriven_a: assert property ((pin_oe_q & ~$past(dir_q)) == '0)
      else $error("input-direction line is driven");

   open_drain_a: assert property ((pin_oe_q & pin_o_q & ~$past(drv_q)) == '0)
      else $error("open-drain line driven high");

   push_pull_a: assert property (##1 (pin_oe_q == ($past(dir_q & drv_q) |
      $past(dir_q & ~drv_q & ~out_q))) && ((pin_o_q & pin_oe_q) == $past(out_q & drv_q & dir_q)))
      else $error("pin drive does not match configuration");

   out_hold_a: assert property (!wr_out && !wr_dir && !wr_drv |=> ##1
      $stable(pin_oe_q) && $stable(pin_o_q))
      else $error("pins changed without a software write");

   trig_edge_a: assert property (trig_q |-> $past(func_q.armed) &&
      $past(func_q.mode == dtc_pkg::FN_TRIGGER) && $past(sel_edge) ##1 !trig_q)
      else $error("start trigger without armed selected edge");

   trig_mode_a: assert property (func_q.mode == dtc_pkg::FN_COUNTER |=> !trig_q)
      else $error("trigger fired in counter mode");

   count_fall_a: assert property (func_q.mode == dtc_pkg::FN_COUNTER && fn_fall && !wr_cnt
      |=> cnt_q == $past(cnt_q) + dtc_pkg::CNT_ONE)
      else $error("falling edge not counted");

   count_rise_a: assert property (!fn_fall && !wr_cnt |=> $stable(cnt_q))
      else $error("counter moved without falling edge");

   count_wrap_a: assert property (cnt_q == '1 && fn_fall && !wr_cnt &&
      func_q.mode == dtc_pkg::FN_COUNTER |=> cnt_q == dtc_pkg::CNT_RST)
      else $error("counter did not wrap to zero");

   aux_suspend_a: assert property (bus_suspend_i [*2] |=> !aux_q)
      else $error("auxiliary supply on during suspend");

   aux_follow_a: assert property (!bus_suspend_i |=> aux_q)
      else $error("auxiliary supply off outside suspend");

   // Bookkeeping checks on the software-visible registers
   dir_write_a: assert property (wr_dir |=> dir_q == $past(wr_data_i[L-1:0]))
      else $error("direction write not taken");

   out_write_a: assert property (wr_out |=> out_q == $past(wr_data_i[L-1:0]))
      else $error("output write not taken");

   drive_write_a: assert property (wr_drv |=> drv_q == $past(wr_data_i[L-1:0]))
      else $error("drive style write not taken");

   func_write_a: assert property (wr_func |=>
      func_q.mode == $past(dtc_pkg::dtc_func_e'(wr_data_i[dtc_pkg::FB_MODE])) &&
      func_q.fall_edge == $past(wr_data_i[dtc_pkg::FB_FALL]))
      else $error("function write not taken");

   arm_mode_a: assert property (func_q.mode == dtc_pkg::FN_COUNTER
      |-> !func_q.armed)
      else $error("trigger armed in counter mode");

   arm_hold_a: assert property (func_q.armed && !sel_edge && !wr_func
      |=> func_q.armed)
      else $error("trigger disarmed without its edge");

   fired_set_a: assert property (trig_q |-> func_q.fired && !func_q.armed)
      else $error("fired flag not set by trigger");

   count_mode_a: assert property (func_q.mode == dtc_pkg::FN_TRIGGER && !wr_cnt
      |=> $stable(cnt_q))
      else $error("counter moved in trigger mode");

   count_load_a: assert property (wr_cnt && func_q.mode == dtc_pkg::FN_TRIGGER
      |=> cnt_q == $past(wr_data_i))
      else $error("counter load not taken");

   // Read data stand for one cycle only; an idle bus reads as zero
   rd_idle_a: assert property (!rd_i |=> rd_data_q == dtc_pkg::DATA_ZERO)
      else $error("read data without a read");

   in_sample_a: assert property (rd_i && addr_i == dtc_pkg::OFS_IN
      |=> rd_data_q[L-1:0] == $past(pins_sync))
      else $error("input read does not match sampled pins");

   trig_fire_c: cover property (func_q.armed ##[1:50] trig_q);
   count_wrap_c: cover property (cnt_q == '1 ##1 cnt_q == dtc_pkg::CNT_RST);
   suspend_cycle_c: cover property (aux_q ##1 !aux_q ##[1:20] aux_q);
   push_pull_c: cover property ((pin_oe_q & pin_o_q) != '0);
   in_read_c: cover property (rd_i && addr_i == dtc_pkg::OFS_IN);
endmodule
`default_nettype wire

// ### sim/dtc_line_model.sv
// Model of the outside world on the twelve lines: pull-ups and optional outside drivers
`timescale 1ns/1ps
`default_nettype none
module dtc_line_model (
   input wire logic [11:0] dev_o_i,
   input wire logic [11:0] dev_oe_i,
   input wire logic [11:0] ext_en_i,
   input wire logic [11:0] ext_val_i,
   output logic [11:0] level_o
);
   always_comb begin
      for (int i = 0; i < 12; i++) begin
         if (dev_oe_i[i]) begin
            level_o[i] = dev_o_i[i];
         end else if (ext_en_i[i]) begin
            level_o[i] = ext_val_i[i];
         end else begin
            // Released line goes to its pull-up, never a stale value
            level_o[i] = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ### sim/dtc_dio_bench.sv
// Self-checking bench for the digital I/O and trigger counter block
`timescale 1ns/1ps
`default_nettype none
module dtc_dio_bench;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wr_data_i = 32'h0000_0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic func_in = 1'b1;
   logic suspend = 1'b0;
   logic [11:0] ext_en = 12'h000;
   logic [11:0] ext_val = 12'h000;
   logic [31:0] rd_data;
   logic [7:0] wide_o;
   logic [7:0] wide_oe;
   logic [3:0] nar_o;
   logic [3:0] nar_oe;
   logic trig;
   logic aux;
   logic [11:0] level;
   logic [31:0] v;
   int bad_count = 0;
   int cmp_count = 0;
   int n;

   dtc_dio dut (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
      .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data), .wide_port_lines_i(level[7:0]),
      .wide_port_lines_o(wide_o), .wide_port_lines_oe_o(wide_oe),
      .narrow_port_lines_i(level[11:8]), .narrow_port_lines_o(nar_o),
      .narrow_port_lines_oe_o(nar_oe), .function_input_i(func_in),
      .acquisition_start_trigger_o(trig), .bus_suspend_i(suspend), .aux_supply_en_o(aux));

   dtc_line_model lines (.dev_o_i({nar_o, wide_o}), .dev_oe_i({nar_oe, wide_oe}),
      .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(level));

   initial begin
      forever #2.5 clock_i = ~clock_i;
   end

   task automatic print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wr_data_i <= d;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 d = rd_data;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clock_i);
      #1;
   endtask

   // Each level is held four clocks so the synchroniser sees it
   task automatic drive_fi(input logic lvl);
      @(posedge clock_i);
      func_in <= lvl;
      cyc(4);
   endtask

   initial begin
      // Reset is sampled high at six edges and released on the sixth
      repeat (6) @(posedge clock_i);
      reset_i <= 1'b0;
      #1;
      chk({20'h0_0000, nar_oe, wide_oe}, 32'h0000_0000);
      // Arm at once: the idle-high function input must not pass for a rising edge
      wr(dtc_pkg::OFS_FUNC, 32'h0000_0004);
      cyc(2);
      chk({31'h0, aux}, 32'h0000_0001);
      rd(dtc_pkg::OFS_DIR, v);
      chk(v, 32'h0000_0000);
      rd(dtc_pkg::OFS_FUNC, v);
      chk(v, 32'h0000_0004);
      wr(dtc_pkg::OFS_DIR, 32'h0000_0105);
      wr(dtc_pkg::OFS_OUT, 32'h0000_0104);
      cyc(2);
      chk({20'h0_0000, nar_oe, wide_oe}, 32'h0000_0001);
      chk({31'h0, wide_o[0]}, 32'h0000_0000);
      wr(dtc_pkg::OFS_DRIVE, 32'h0000_0104);
      cyc(2);
      chk({20'h0_0000, nar_oe, wide_oe}, 32'h0000_0105);
      chk({20'h0_0000, nar_o & nar_oe, wide_o & wide_oe}, 32'h0000_0104);
      @(posedge clock_i);
      ext_en <= 12'h0F0;
      ext_val <= 12'h050;
      cyc(3);
      rd(dtc_pkg::OFS_IN, v);
      chk(v, 32'h0000_0F5E);
      rd(8'h40, v);
      chk(v, 32'h0000_0000);
      wr(dtc_pkg::OFS_FUNC, 32'h0000_0001);
      wr(dtc_pkg::OFS_COUNT, 32'hFFFF_FFFE);
      for (int i = 0; i < 3; i++) begin
         drive_fi(1'b0);
         drive_fi(1'b1);
      end
      rd(dtc_pkg::OFS_COUNT, v);
      chk(v, 32'h0000_0001);
      for (int e = 0; e < 2; e++) begin
         drive_fi(e[0]);
         wr(dtc_pkg::OFS_FUNC, {29'h0, 1'b1, e[0], 1'b0});
         n = 0;
         for (int k = 0; k < 24; k++) begin
            @(posedge clock_i);
            if (k == 6) begin
               func_in <= ~e[0];
            end
            if (k == 14) begin
               func_in <= e[0];
            end
            #1;
            if (trig === 1'b1 && k < 6) begin
               n = n + 10;
            end else if (trig === 1'b1) begin
               n++;
            end
         end
         chk(n, 32'h0000_0001);
         rd(dtc_pkg::OFS_FUNC, v);
         chk(v, {28'h0, 1'b1, 1'b0, e[0], 1'b0});
      end
      @(posedge clock_i);
      suspend <= 1'b1;
      cyc(2);
      chk({31'h0, aux}, 32'h0000_0000);
      rd(dtc_pkg::OFS_STATUS, v);
      chk(v, 32'h0000_0001);
      @(posedge clock_i);
      suspend <= 1'b0;
      cyc(2);
      chk({31'h0, aux}, 32'h0000_0001);
      print_verdict();
   end

   initial begin
      repeat (3000) @(posedge clock_i);
      bad_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
